/* design/flash_seq_pkg.sv */
// flash write sequencer constants: register offsets, fields, keys, timing
// assumes a 10 MHz core clock and an 8-bit register port
package flash_seq_pkg;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          ERASE_TIME_US = 4000;
  localparam int          ERASE_CYCLES  = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          SETUP_CYCLES  = 2;
  localparam int          ADDR_W        = 13;
  localparam int          WORD_W        = 14;
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'haa;
  localparam logic [3:0]  OFS_DATA_LOW  = 4'h0;
  localparam logic [3:0]  OFS_ADDR_LOW  = 4'h1;
  localparam logic [3:0]  OFS_DATA_HIGH = 4'h2;
  localparam logic [3:0]  OFS_ADDR_HIGH = 4'h3;
  localparam logic [3:0]  OFS_CTRL      = 4'h4;
  localparam logic [3:0]  OFS_UNLOCK    = 4'h5;
  localparam logic [3:0]  OFS_STATUS    = 4'h6;
  localparam int          BIT_SPACE     = 7;
  localparam int          BIT_ERR       = 3;
  localparam int          BIT_ALLOW     = 2;
  localparam int          BIT_GO        = 1;
  localparam int          BIT_DONE      = 0;
  localparam logic [1:0]  SLOT_LAST     = 2'b11;
  localparam logic [1:0]  PROT_NONE     = 2'b11;
  localparam logic [1:0]  PROT_LOW_QTR  = 2'b10;
  localparam logic [1:0]  PROT_LOW_HALF = 2'b01;
  localparam logic [ADDR_W-1:0] QTR_END  = 13'h0400;
  localparam logic [ADDR_W-1:0] HALF_END = 13'h1000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROG  = 4'b1000
  } seq_state_t;
endpackage

/* design/flash_array_if.sv */
// carrier between sequencer and flash array port
interface flash_array_if;
  import flash_seq_pkg::*;
  logic              erase;
  logic              prog;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata;
  modport seq   (output erase, output prog, output addr, output wdata);
  modport array (input erase, input prog, input addr, input wdata);
endinterface

/* design/flash_block_buffer.sv */
// four-slot word buffer that stages one block before commit
// assumes writes come from the sequencer on the same clock
module flash_block_buffer
  import flash_seq_pkg::*;
#(
  parameter int SLOTS = 4
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(SLOTS)-1:0] wr_slot,
  input  wire logic [WORD_W-1:0]        wr_word,
  input  wire logic [$clog2(SLOTS)-1:0] rd_slot,
  output logic      [WORD_W-1:0]        rd_word
);
  typedef struct packed {
    logic [SLOTS-1:0][WORD_W-1:0] mem;
  } buf_state_t;

  buf_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_slot] = wr_word;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_word = s_q.mem[rd_slot];
endmodule

/* design/flash_block_write_sequencer.sv */
// self-programming sequencer for four-word block erase-and-write of flash
// assumes the core drives the register port on clk and obeys core_stall
module flash_block_write_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ERASE_LEN = ERASE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              warm_reset,
  input  wire logic [1:0]        protect_range_field,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   core_squash,
  output logic                   core_stall,
  output logic                   flash_erase,
  output logic                   flash_prog,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [WORD_W-1:0] flash_wdata
);
  localparam int CNT_W = $clog2(ERASE_LEN + 1);

  typedef struct packed {
    seq_state_t        st;
    logic [7:0]        addr_low_reg;
    logic [4:0]        addr_high_reg;
    logic [7:0]        data_low_reg;
    logic [5:0]        data_high_reg;
    logic              space_select;
    logic              program_allow;
    logic              abort_error_flag;
    logic              go;
    logic              done_irq_flag;
    logic              key1_seen;
    logic              key2_seen;
    logic              commit;
    logic [1:0]        prog_slot;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        rdata;
  } seq_q_t;

  seq_q_t q, d;
  flash_array_if fa ();

  logic [ADDR_W-1:0] cur_addr;
  logic              wr_ctrl, wr_unlock, go_req, addr_ok, buf_wr;
  logic [WORD_W-1:0] buf_rd_word;

  // protected segments grow upward from address zero
  function automatic logic is_protected(input logic [1:0] rng, input logic [ADDR_W-1:0] a);
    unique case (rng)
      PROT_NONE:     is_protected = 1'b0;
      PROT_LOW_QTR:  is_protected = (a < QTR_END);
      PROT_LOW_HALF: is_protected = (a < HALF_END);
      default:       is_protected = 1'b1;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] block_word(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0] slot);
    block_word = {a[ADDR_W-1:2], slot};
  endfunction

  assign cur_addr  = {q.addr_high_reg, q.addr_low_reg};
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_unlock = reg_wr && (reg_addr == OFS_UNLOCK);
  // go honoured only after both keys, with allow and program space set
  assign go_req    = wr_ctrl && reg_wdata[BIT_GO] && !q.go && q.key2_seen
                     && q.program_allow
                     && reg_wdata[BIT_SPACE] && q.space_select;
  assign addr_ok   = !is_protected(protect_range_field, cur_addr);
  assign buf_wr    = go_req && addr_ok && (q.st == ST_IDLE);

  flash_block_buffer #(
    .SLOTS(4)
  ) u_buf (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (buf_wr),
    .wr_slot (cur_addr[1:0]),
    .wr_word ({q.data_high_reg, q.data_low_reg}),
    .rd_slot (q.prog_slot),
    .rd_word (buf_rd_word)
  );

  always_comb begin
    d = q;
    d.rdata = 8'h00;
    if (reg_wr) begin
      // any write other than the expected key breaks the unlock chain
      d.key1_seen = wr_unlock && (reg_wdata == KEY_FIRST);
      d.key2_seen = wr_unlock && (reg_wdata == KEY_SECOND) && q.key1_seen;
      if (q.st == ST_IDLE) begin
        unique case (reg_addr)
          OFS_ADDR_LOW:  d.addr_low_reg  = reg_wdata;
          OFS_ADDR_HIGH: d.addr_high_reg = reg_wdata[4:0];
          OFS_DATA_LOW:  d.data_low_reg  = reg_wdata;
          OFS_DATA_HIGH: d.data_high_reg = reg_wdata[5:0];
          OFS_STATUS:    if (!reg_wdata[BIT_DONE]) d.done_irq_flag = 1'b0;
          default:       ;
        endcase
      end
      if (wr_ctrl) begin
        d.program_allow    = reg_wdata[BIT_ALLOW];
        d.abort_error_flag = reg_wdata[BIT_ERR];
        if (!q.go) begin
          d.space_select = reg_wdata[BIT_SPACE];
        end
      end
    end
    if (go_req && buf_wr) begin
      d.go     = 1'b1;
      d.st     = ST_SETUP;
      d.cnt    = '0;
      d.commit = (cur_addr[1:0] == SLOT_LAST);
    end
    unique case (q.st)
      ST_IDLE: ;
      ST_SETUP: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(SETUP_CYCLES - 1)) begin
          d.cnt = '0;
          if (q.commit) begin
            d.st = ST_ERASE;
          end else begin
            d.st            = ST_IDLE;
            d.go            = 1'b0;
            d.done_irq_flag = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(ERASE_LEN - 1)) begin
          d.cnt       = '0;
          d.prog_slot = 2'b00;
          d.st        = ST_PROG;
        end
      end
      ST_PROG: begin
        d.prog_slot = q.prog_slot + 1'b1;
        if (q.prog_slot == SLOT_LAST) begin
          d.st            = ST_IDLE;
          d.go            = 1'b0;
          d.done_irq_flag = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // warm reset cuts a write short and leaves the error flag as evidence
    if (warm_reset) begin
      if (q.st != ST_IDLE) begin
        d.abort_error_flag = 1'b1;
      end
      d.st            = ST_IDLE;
      d.go            = 1'b0;
      d.program_allow = 1'b0;
      d.key1_seen     = 1'b0;
      d.key2_seen     = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_ADDR_LOW:  d.rdata = q.addr_low_reg;
        OFS_ADDR_HIGH: d.rdata = {3'h0, q.addr_high_reg};
        OFS_DATA_LOW:  d.rdata = q.data_low_reg;
        OFS_DATA_HIGH: d.rdata = {2'h0, q.data_high_reg};
        OFS_CTRL:      d.rdata = {q.space_select, 3'h0, q.abort_error_flag,
                                  q.program_allow, q.go, 1'b0};
        OFS_STATUS:    d.rdata = {7'h00, q.done_irq_flag};
        default:       d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata   = q.rdata;
  // squash the two setup slots; only a commit goes on to stall
  assign core_squash = (q.st == ST_SETUP);
  assign core_stall  = (q.st == ST_SETUP) || (q.st == ST_ERASE) || (q.st == ST_PROG);
  // only the core is held; clk is never gated so peripherals run on
  assign fa.erase    = (q.st == ST_ERASE) && (q.cnt == '0);
  assign fa.prog     = (q.st == ST_PROG);
  assign fa.addr     = (q.st == ST_PROG) ? block_word(cur_addr, q.prog_slot)
                                          : block_word(cur_addr, 2'b00);
  assign fa.wdata    = buf_rd_word;
  assign flash_erase = fa.erase;
  assign flash_prog  = fa.prog;
  assign flash_addr  = fa.addr;
  assign flash_wdata = fa.wdata;

  // unlock and go qualification
  a_go_needs_allow: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.go) |-> $past(q.program_allow) && $past(q.key2_seen))
    else $error("go set without allow and keys");

  a_key_pairing: assert property (@(posedge clk) disable iff (!resetn)
    q.key2_seen |-> $past(q.key1_seen))
    else $error("second key without first");

  a_key_chain_break: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr && !wr_unlock |=> !q.key1_seen && !q.key2_seen)
    else $error("unlock chain survived other write");

  a_go_space_set: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.go) |-> $past(q.space_select))
    else $error("go set outside program space");

  a_go_from_idle: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.go) |-> $past(q.st == ST_IDLE))
    else $error("go accepted while busy");

  a_protect_block: assert property (@(posedge clk) disable iff (!resetn)
    go_req && is_protected(protect_range_field, cur_addr) |=> !q.go)
    else $error("protected address accepted");

  // go mirrors the busy state, so software can never clear it early
  a_go_tracks_busy: assert property (@(posedge clk) disable iff (!resetn)
    q.go == (q.st != ST_IDLE))
    else $error("go and busy state disagree");

  a_commit_final_slot: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.go) |-> q.commit == (cur_addr[1:0] == SLOT_LAST))
    else $error("commit not tied to final slot");

  // setup slots and the short path for the first three words
  a_setup_two: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == ST_IDLE) ##1 (q.st == ST_SETUP) |-> (q.st == ST_SETUP) [*2])
    else $error("setup not two cycles");

  a_squash_len: assert property (@(posedge clk) disable iff (!resetn || warm_reset)
    $rose(core_squash) |-> core_squash [*2] ##1 !core_squash)
    else $error("squash window not two cycles");

  a_partial_nostall: assert property (@(posedge clk) disable iff (!resetn || warm_reset)
    $rose(q.go) && !q.commit |-> ##2 !core_stall && !q.go)
    else $error("partial word stalled");

  a_done_partial: assert property (@(posedge clk) disable iff (!resetn || warm_reset)
    $rose(q.go) && !q.commit |-> ##2 q.done_irq_flag)
    else $error("partial word not reported done");

  // erase and program burst
  a_erase_aligned: assert property (@(posedge clk) disable iff (!resetn)
    flash_erase |-> flash_addr[1:0] == 2'b00 && q.commit)
    else $error("erase unaligned or uncommitted");

  a_erase_at_start: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.st == ST_ERASE) |-> flash_erase)
    else $error("erase state without erase pulse");

  a_erase_one_pulse: assert property (@(posedge clk) disable iff (!resetn)
    flash_erase |=> !flash_erase)
    else $error("erase pulse longer than one cycle");

  a_erase_commit_only: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == ST_ERASE) |-> q.commit)
    else $error("long stall on a partial word");

  // antecedent on the entry to programming, so an abort mid-erase does not trip it
  a_prog_after_erase: assert property (@(posedge clk) disable iff (!resetn || warm_reset)
    $rose(q.st == ST_PROG) |-> flash_prog [*4] ##1 !flash_prog)
    else $error("program burst not four words");

  a_first_slot: assert property (@(posedge clk) disable iff (!resetn)
    $rose(flash_prog) |-> flash_addr[1:0] == 2'b00)
    else $error("program burst not from slot zero");

  a_slot_ascend: assert property (@(posedge clk) disable iff (!resetn)
    flash_prog && $past(flash_prog) |-> flash_addr[1:0] == $past(flash_addr[1:0]) + 2'b01)
    else $error("program slots out of order");

  a_prog_in_block: assert property (@(posedge clk) disable iff (!resetn)
    flash_prog |-> flash_addr[ADDR_W-1:2] == cur_addr[ADDR_W-1:2])
    else $error("program left block");

  a_stage_frozen: assert property (@(posedge clk) disable iff (!resetn)
    (q.st != ST_IDLE) |=> $stable(cur_addr))
    else $error("staged address moved while busy");

  a_no_flash_idle: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == ST_IDLE) |-> !flash_erase && !flash_prog)
    else $error("flash action while idle");

  // completion and abort
  a_resume_after_burst: assert property (@(posedge clk) disable iff (!resetn)
    $fell(flash_prog) |-> !core_stall)
    else $error("stall held after program burst");

  // an abort also drops go, but that is not a completion
  a_done_set: assert property (@(posedge clk) disable iff (!resetn || warm_reset)
    $fell(q.go) && !$past(warm_reset) |-> q.done_irq_flag)
    else $error("done flag missing at completion");

  a_abort_flag: assert property (@(posedge clk) disable iff (!resetn)
    warm_reset && q.st != ST_IDLE |=> q.abort_error_flag)
    else $error("abort not flagged");

  a_abort_clears: assert property (@(posedge clk) disable iff (!resetn)
    warm_reset |=> !q.program_allow && !q.go)
    else $error("abort left allow or go set");
endmodule

/* verification/flash_array_model.sv */
// behavioural program flash behind the sequencer's array port
// assumes erase and program beats arrive on the sequencer's clock
module flash_array_model
  import flash_seq_pkg::*;
(
  input wire logic              clk,
  input wire logic              flash_erase,
  input wire logic              flash_prog,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [WORD_W-1:0] flash_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] base_q;
  int                erases;
  int                stray;
  initial begin
    erases = 0;
    stray = 0;
    base_q = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  always @(posedge clk) begin
    if (flash_erase) begin
      base_q <= flash_addr;
      erases <= erases + 1;
      // erased cells read as all ones, so a skipped beat shows
      for (int i = 0; i < 4; i++) mem[{flash_addr[ADDR_W-1:2], i[1:0]}] <= '1;
    end
    if (flash_prog) begin
      mem[flash_addr] <= flash_wdata;
      if (flash_addr[ADDR_W-1:2] !== base_q[ADDR_W-1:2]) stray <= stray + 1;
    end
  end
endmodule

/* verification/tb.sv */
// register-level bench for the flash block write sequencer
// assumes a shortened erase count and the flash model on the array port
module tb
  import flash_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EL = 20;
  logic              clk, resetn, warm_reset, reg_wr, reg_rd;
  logic              core_squash, core_stall, flash_erase, flash_prog;
  logic [1:0]        protect_range_field;
  logic [3:0]        reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, d;
  logic [ADDR_W-1:0] flash_addr;
  logic [WORD_W-1:0] flash_wdata;
  int                mismatches, n_checks, n, sq;

  flash_block_write_sequencer #(.ERASE_LEN(EL)) flash_block_write_sequencer_i (
    .clk(clk), .resetn(resetn), .warm_reset(warm_reset),
    .protect_range_field(protect_range_field), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_squash(core_squash), .core_stall(core_stall), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  flash_array_model flash_array_model_i (
    .clk(clk), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes stay up at return so back-to-back calls never assign twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge clk);
  endtask
  // counts stalled and squashed cycles from the edge that took go
  task automatic measure;
    n = 0;
    sq = 0;
    reg_wr <= 1'b0;
    for (int i = 0; i <= EL + 40; i++) begin
      #1;
      if (core_stall !== 1'b1) break;
      n++;
      if (core_squash === 1'b1) sq++;
      @(posedge clk);
    end
    if (n > EL + 40) begin
      mismatches++;
      finish_test();
    end
  endtask
  // mode 1 breaks the key pair, mode 2 aborts by warm reset
  task automatic xfer(input logic [12:0] a, input logic [13:0] w, input logic [7:0] go,
                      input int mode);
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_ADDR_HIGH, {3'h0, a[12:8]});
    wr(OFS_DATA_LOW, w[7:0]);
    wr(OFS_DATA_HIGH, {2'h0, w[13:8]});
    wr(OFS_CTRL, go & 8'hfd);
    wr(OFS_UNLOCK, KEY_FIRST);
    if (mode == 1) wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, go);
    if (mode == 2) begin
      reg_wr <= 1'b0;
      repeat (6) @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
    end else begin
      measure();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {resetn, warm_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    protect_range_field = PROT_NONE;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, d);
    chk("ctrl allow go", 16'(d & 8'h06), 16'h0000);
    rd(4'hf, d);
    chk("unmapped", 16'(d), 16'h0000);
    xfer(13'h1007, 14'h0aaa, 8'h86, 1);
    chk("split keys", 16'(n), 16'h0000);
    xfer(13'h1007, 14'h0aaa, 8'h82, 0);
    chk("no allow", 16'(n), 16'h0000);
    protect_range_field <= PROT_LOW_QTR;
    xfer(13'h0103, 14'h0aaa, 8'h86, 0);
    chk("protected", 16'(n), 16'h0000);
    protect_range_field <= PROT_NONE;
    chk("no flash action", 16'(flash_array_model_i.erases), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      xfer(13'h1004 + 13'(i), 14'h1230 + 14'(i), 8'h86, 0);
      chk("squash", 16'(sq), 16'h0002);
      if (i < 3) chk("short stall", 16'(n), 16'h0002);
      else chk("long stall", 16'(n >= EL + 6 && n <= EL + 8), 16'h0001);
      chk("erases", 16'(flash_array_model_i.erases), 16'(i == 3));
      rd(OFS_DATA_LOW, d);
      chk("staged word", 16'(d), 16'h0030 + 16'(i));
      rd(OFS_CTRL, d);
      chk("go cleared", 16'(d[BIT_GO]), 16'h0000);
      rd(OFS_STATUS, d);
      chk("done set", 16'(d[BIT_DONE]), 16'h0001);
      wr(OFS_STATUS, 8'h00);
      rd(OFS_STATUS, d);
      chk("done cleared", 16'(d[BIT_DONE]), 16'h0000);
    end
    chk("erase base", 16'(flash_array_model_i.base_q), 16'h1004);
    chk("stray beats", 16'(flash_array_model_i.stray), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      chk("word", 16'(flash_array_model_i.mem[13'h1004 + 13'(i)]), 16'h1230 + 16'(i));
    end
    xfer(13'h100b, 14'h0555, 8'h86, 2);
    rd(OFS_CTRL, d);
    chk("abort err", 16'(d[BIT_ERR]), 16'h0001);
    chk("stall released", 16'(core_stall), 16'h0000);
    finish_test();
  end
endmodule
